//--- verilog/ufl_core.sv
// serial frame, synchronous clock and lin control block with apb registers
//
// Added by the designer: the APB register port.
`default_nettype none
// Functional notes
// - second control register resets to zero
// - lin break sends 13 low bits; detect breaks
// - clock pin pulses only when enabled
// - idle clock pin level equals polarity bit
// - phase bit picks first or second capture edge
// - last data bit pulse only when enabled
// - break sets flag, interrupts when enabled
// - break detect needs 10 or 11 low bits
// - address wake compares 4-bit node address
// - hardware clears break request after its stop
// - wake on idle line or matching address
module ufl_core
    import ufl_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
    input wire logic clock,            // peripheral clock
    input wire logic nrst,             // async reset, low active
    input wire logic psel,             // apb select
    input wire logic penable,          // apb access phase
    input wire logic pwrite,           // apb direction
    input wire logic [11:0] paddr,     // apb byte address
    input wire logic [31:0] pwdata,    // apb write data
    output logic [31:0] prdata,        // apb read data
    output logic pready,               // apb ready
    output logic pslverr,              // apb error, unmapped address
    output logic irq,                  // level interrupt
    input wire logic rx_pin,           // serial line in, async
    output logic tx_pin,               // serial line out
    output logic sync_clock_pin,       // synchronous clock out
    output logic sync_clock_pin_oe     // clock pin output enable
);
    localparam logic [15:0] HALF_M1 = 16'(BIT_CYCLES / 2 - 1);
    localparam logic [15:0] BIT_M1 = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] FIRST_M1 = 16'(BIT_CYCLES + BIT_CYCLES / 2 - 1);
    // the run counter restarts one cycle into a level, so a run of n
    // cycles is complete on the cycle where the counter shows n - 2
    localparam logic [15:0] DET_S_M2 = 16'(DET_SHORT_BITS * BIT_CYCLES - 2);
    localparam logic [15:0] DET_L_M2 = 16'(DET_LONG_BITS * BIT_CYCLES - 2);
    localparam logic [15:0] IDLE_M2 = 16'(IDLE_BITS * BIT_CYCLES - 2);
    localparam logic [4:0] LIN_BRK_H = 5'(2 * LIN_BRK_BITS - 1);
    localparam logic [4:0] STD_BRK_H = 5'(2 * STD_BRK_BITS - 1);
    localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);
    localparam int LIN_BRK_CYC = LIN_BRK_BITS * BIT_CYCLES;

    if (BIT_CYCLES < 2 || BIT_CYCLES % 2 != 0 || BIT_CYCLES > 4096)
    begin : g_bad_bit
        $error("BIT_CYCLES must be even, 2 to 4096");
    end

    // ************************************************************
    // state
    // ************************************************************
    ufl_cr2_t cr2_q, cr2_d;
    logic [CTL_W-1:0] ctl_q, ctl_d;
    logic [ST_W-1:0] sts_q, sts_d, ev;
    logic [ST_W-1:1] msk_q, msk_d;
    logic [7:0] txd_q, txd_d, rxb_q, rxb_d;
    logic [31:0] prd_q, prd_d;
    logic rdy_q, rdy_d, err_q, err_d, irq_q, irq_d;
    ufl_pins_t pins_q, pins_d;
    ufl_tx_st_t tst_q, tst_d;
    logic [15:0] tcyc_q, tcyc_d;
    logic [4:0] hn_q, hn_d;
    logic [2:0] tix_q, tix_d;
    logic [7:0] tsh_q, tsh_d;
    logic brk_q, brk_d, go, sbk_clr, ev_txd;
    logic rx_m_q, rx_s_q, rx_p_q;
    ufl_rx_st_t rst_q, rst_d;
    logic [15:0] lc_q, lc_d, rc_q, rc_d;
    logic [2:0] rix_q, rix_d;
    logic [7:0] rsh_q, rsh_d;
    logic ev_brk, ev_wake;
    logic wr, hit;

    assign prdata = prd_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
    assign irq = irq_q;
    assign tx_pin = pins_q.tx;
    assign sync_clock_pin = pins_q.ck;
    assign sync_clock_pin_oe = pins_q.ck_oe;

    // ************************************************************
    // apb slave and registers
    // ************************************************************
    // one wait state: ready rises after the first access cycle, and the
    // write lands on the edge where the master sees ready high
    always_comb begin
        wr = psel && penable && rdy_q && pwrite;
        hit = paddr == OFS_CTRL || paddr == OFS_DATA || paddr == OFS_STS
            || paddr == OFS_MSK || paddr == OFS_CR2;
        rdy_d = psel && penable && !rdy_q;
        err_d = rdy_d && !hit;
        prd_d = ZERO_WORD;
        if (rdy_d && !pwrite) begin
            unique case (paddr)
                OFS_CTRL: prd_d[CTL_W-1:0] = ctl_q;
                OFS_DATA: prd_d[7:0] = rxb_q;
                OFS_STS: begin
                    prd_d[ST_W-1:0] = sts_q;
                    prd_d[RD_BUSY] = tst_q != T_IDLE;
                    prd_d[RD_MUTE] = ctl_q[CTL_MUTE];
                end
                OFS_MSK: prd_d[ST_W-1:0] = {msk_q, cr2_q.break_detect_irq_on};
                OFS_CR2: prd_d = cr2_q;
                default: prd_d = ZERO_WORD;
            endcase
        end
        cr2_d = cr2_q;
        ctl_d = ctl_q;
        msk_d = msk_q;
        txd_d = txd_q;
        go = 1'b0;
        if (sbk_clr) ctl_d[CTL_SBK] = 1'b0;
        if (ev_wake) ctl_d[CTL_MUTE] = 1'b0;
        sts_d = sts_q;
        if (wr) begin
            unique case (paddr)
                OFS_CTRL: ctl_d = pwdata[CTL_W-1:0];
                OFS_DATA: begin
                    txd_d = pwdata[7:0];
                    go = 1'b1;
                end
                OFS_STS: sts_d = sts_q & ~pwdata[ST_W-1:0];
                OFS_MSK: msk_d = pwdata[ST_W-1:1];
                OFS_CR2: cr2_d = pwdata & CR2_WMASK;
                default: ;
            endcase
        end
        // a hardware event in the clearing cycle still sets its flag
        ev = {ev_wake, ev_txd, ev_brk};
        sts_d = sts_d | ev;
        irq_d = |(sts_d & {msk_d, cr2_d.break_detect_irq_on});
    end

    // register the bus side
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cr2_q <= CR2_RST;
            ctl_q <= CTL_RST;
            sts_q <= ST_RST;
            msk_q <= '0;
            txd_q <= '0;
            rxb_q <= '0;
            prd_q <= ZERO_WORD;
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            cr2_q <= cr2_d;
            ctl_q <= ctl_d;
            sts_q <= sts_d;
            msk_q <= msk_d;
            txd_q <= txd_d;
            rxb_q <= rxb_d;
            prd_q <= prd_d;
            rdy_q <= rdy_d;
            err_q <= err_d;
            irq_q <= irq_d;
        end
    end

    // ************************************************************
    // transmitter and synchronous clock
    // ************************************************************
    // time runs in half bits so that half stop bits fall out naturally;
    // a data write while busy is dropped, software polls the busy bit
    always_comb begin
        tst_d = tst_q;
        tcyc_d = tcyc_q;
        hn_d = hn_q;
        tix_d = tix_q;
        tsh_d = tsh_q;
        brk_d = brk_q;
        sbk_clr = 1'b0;
        ev_txd = 1'b0;
        if (tst_q != T_IDLE) begin
            if (tcyc_q != '0) tcyc_d = tcyc_q - 16'h0001;
            else begin
                tcyc_d = HALF_M1;
                if (hn_q != '0) hn_d = hn_q - 5'h01;
            end
        end
        if (tst_q == T_IDLE || (tcyc_q == '0 && hn_q == '0)) begin
            unique case (tst_q)
                T_IDLE: begin
                    tcyc_d = HALF_M1;
                    if (ctl_q[CTL_SBK]) begin
                        tst_d = T_BRK;
                        brk_d = 1'b1;
                        hn_d = cr2_q.lin_mode_on ? LIN_BRK_H : STD_BRK_H;
                    end else if (go) begin
                        tst_d = T_START;
                        brk_d = 1'b0;
                        tsh_d = txd_d;
                        hn_d = 5'h01;
                    end
                end
                T_START, T_BRK: begin
                    tst_d = tst_q == T_BRK ? T_STOP : T_DATA;
                    tix_d = '0;
                    hn_d = 5'h01;
                    if (tst_q == T_BRK) hn_d = STOP_H_1 - 5'h01;
                end
                T_DATA: begin
                    hn_d = 5'h01;
                    tsh_d = tsh_q >> 1;
                    tix_d = tix_q + 3'h1;
                    if (tix_q == LAST_BIT) begin
                        tst_d = T_STOP;
                        unique case (cr2_q.stop_len)
                            2'b00: hn_d = STOP_H_1 - 5'h01;
                            2'b01: hn_d = STOP_H_05 - 5'h01;
                            2'b10: hn_d = STOP_H_2 - 5'h01;
                            2'b11: hn_d = STOP_H_15 - 5'h01;
                        endcase
                    end
                end
                T_STOP: begin
                    tst_d = T_IDLE;
                    sbk_clr = brk_q;
                    ev_txd = !brk_q;
                end
                default: tst_d = T_IDLE;
            endcase
        end
        pins_d.tx = !(tst_q == T_START || tst_q == T_BRK);
        if (tst_q == T_DATA) pins_d.tx = tsh_q[0];
        // active half: second half for phase 0, first half for phase 1
        pins_d.ck = cr2_q.sync_clock_idle_level;
        if (tst_q == T_DATA && cr2_q.sync_clock_pin_on
            && (tix_q != LAST_BIT || cr2_q.final_bit_pulse_on)
            && ((hn_q == '0) != cr2_q.sync_clock_capture_phase))
            pins_d.ck = !cr2_q.sync_clock_idle_level;
        pins_d.ck_oe = cr2_q.sync_clock_pin_on;
    end

    // register the transmitter
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tst_q <= T_IDLE;
            tcyc_q <= '0;
            hn_q <= '0;
            tix_q <= '0;
            tsh_q <= '0;
            brk_q <= 1'b0;
            pins_q <= '{tx: 1'b1, ck: 1'b0, ck_oe: 1'b0};
        end else begin
            tst_q <= tst_d;
            tcyc_q <= tcyc_d;
            hn_q <= hn_d;
            tix_q <= tix_d;
            tsh_q <= tsh_d;
            brk_q <= brk_d;
            pins_q <= pins_d;
        end
    end

    // ************************************************************
    // receiver, break detect and wake-up
    // ************************************************************
    // one run-length counter serves both break and idle detection
    always_comb begin
        lc_d = lc_q;
        if (rx_s_q != rx_p_q) lc_d = '0;
        else if (lc_q != LC_MAX) lc_d = lc_q + 16'h0001;
        ev_brk = cr2_q.lin_mode_on && !rx_s_q && rx_s_q == rx_p_q
            && lc_q == (cr2_q.break_detect_length ? DET_L_M2 : DET_S_M2);
        ev_wake = 1'b0;
        if (ctl_q[CTL_MUTE] && !ctl_q[CTL_WAKE] && rx_s_q && rx_s_q == rx_p_q
            && lc_q == IDLE_M2) ev_wake = 1'b1;
        rst_d = rst_q;
        rc_d = rc_q;
        rix_d = rix_q;
        rsh_d = rsh_q;
        rxb_d = rxb_q;
        if (rc_q != '0) rc_d = rc_q - 16'h0001;
        unique case (rst_q)
            R_IDLE: if (rx_p_q && !rx_s_q) begin
                rst_d = R_DATA;
                rc_d = FIRST_M1;
                rix_d = '0;
            end
            R_DATA: if (rc_q == '0) begin
                rsh_d = {rx_s_q, rsh_q[7:1]};
                rc_d = BIT_M1;
                rix_d = rix_q + 3'h1;
                if (rix_q == LAST_BIT) rst_d = R_STOP;
            end
            R_STOP: if (rc_q == '0) begin
                rst_d = R_IDLE;
                if (rx_s_q && !ctl_q[CTL_MUTE]) rxb_d = rsh_q;
                if (rx_s_q && ctl_q[CTL_MUTE] && ctl_q[CTL_WAKE] && rsh_q[7]
                    && rsh_q[3:0] == cr2_q.node_addr) ev_wake = 1'b1;
            end
            default: rst_d = R_IDLE;
        endcase
    end

    // two flip-flops guard the line before any logic reads it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
            rx_p_q <= 1'b1;
            rst_q <= R_IDLE;
            lc_q <= '0;
            rc_q <= '0;
            rix_q <= '0;
            rsh_q <= '0;
        end else begin
            rx_m_q <= rx_pin;
            rx_s_q <= rx_m_q;
            rx_p_q <= rx_s_q;
            rst_q <= rst_d;
            lc_q <= lc_d;
            rc_q <= rc_d;
            rix_q <= rix_d;
            rsh_q <= rsh_d;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [15:0] lowc_q, stc_q;
    logic [4:0] stop_h;
    always_comb begin
        unique case (cr2_q.stop_len)
            2'b00: stop_h = STOP_H_1;
            2'b01: stop_h = STOP_H_05;
            2'b10: stop_h = STOP_H_2;
            2'b11: stop_h = STOP_H_15;
        endcase
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lowc_q <= '0;
            stc_q <= '0;
        end else begin
            lowc_q <= pins_q.tx ? 16'h0000 : lowc_q + 16'h0001;
            stc_q <= tst_q == T_STOP ? stc_q + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_reset_zero: assert property ($rose(nrst) |-> cr2_q == CR2_RST)
        else $error("control register not zero after reset");
    a_lin_break: assert property ($rose(pins_q.tx) && brk_q
        && cr2_q.lin_mode_on |-> lowc_q == 16'(LIN_BRK_CYC))
        else $error("lin break not 13 bits low");
    a_stop_len: assert property ($fell(tst_q == T_STOP) && !brk_q
        |-> $past(stc_q) + 16'h0001 == 16'(stop_h * (BIT_CYCLES / 2)))
        else $error("wrong stop length");
    a_ck_disabled: assert property (!cr2_q.sync_clock_pin_on
        |=> !sync_clock_pin_oe && sync_clock_pin == $past(pins_d.ck)
        && (sync_clock_pin == $past(cr2_q.sync_clock_idle_level)))
        else $error("clock pin active while disabled");
    a_ck_idle_lvl: assert property (tst_q != T_DATA
        |=> sync_clock_pin == $past(cr2_q.sync_clock_idle_level))
        else $error("clock pin not at idle level");
    sequence s_data_start;
        $rose(tst_q == T_DATA) && cr2_q.sync_clock_pin_on;
    endsequence
    a_ck_phase: assert property (s_data_start |=> sync_clock_pin ==
        ($past(cr2_q.sync_clock_idle_level)
        ^ $past(cr2_q.sync_clock_capture_phase)))
        else $error("first clock half wrong for phase");
    a_last_pulse: assert property (tst_q == T_DATA && tix_q == LAST_BIT
        && !cr2_q.final_bit_pulse_on
        |=> sync_clock_pin == $past(cr2_q.sync_clock_idle_level))
        else $error("last bit pulse not suppressed");
    a_brk_irq: assert property (ev_brk && cr2_q.break_detect_irq_on
        |=> sts_q[ST_BRK] ##1 irq)
        else $error("break flag or interrupt missing");
    a_sbk_clear: assert property ($fell(ctl_q[CTL_SBK]) && !$past(wr)
        |-> $past(tst_q) == T_STOP && $past(brk_q))
        else $error("break request cleared early");
endmodule : ufl_core
`default_nettype wire

//--- verilog/ufl_pkg.sv
// constants, types and register layout of the frame, clock and lin block
`default_nettype none
package ufl_pkg;
    // ************************************************************
    // register map (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [11:0] OFS_CTRL = 12'h000; // break, mute, wake method
    localparam logic [11:0] OFS_DATA = 12'h004; // wr: tx byte, rd: rx byte
    localparam logic [11:0] OFS_STS = 12'h008;  // sticky events, w1c
    localparam logic [11:0] OFS_MSK = 12'h00c;  // event mask
    localparam logic [11:0] OFS_CR2 = 12'h010;  // serial_ctrl_two

    localparam logic [31:0] CR2_RST = 32'h0000_0000;
    localparam logic [31:0] CR2_WMASK = 32'h0000_7f6f; // bits 7, 4, 31:15 rsvd
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // control register bits
    localparam int CTL_SBK = 0;  // send_break_request, cleared by hardware
    localparam int CTL_MUTE = 1; // receiver muted
    localparam int CTL_WAKE = 2; // 0: idle line wake, 1: address mark wake
    localparam int CTL_W = 3;
    localparam logic [CTL_W-1:0] CTL_RST = 3'h0;

    // status and mask bits
    localparam int ST_BRK = 0;  // break_detected_flag
    localparam int ST_TXD = 1;  // frame sent
    localparam int ST_WAKE = 2; // receiver left mute
    localparam int ST_W = 3;
    localparam int RD_BUSY = 8; // status read: transmitter busy
    localparam int RD_MUTE = 9; // status read: receiver muted
    localparam logic [ST_W-1:0] ST_RST = 3'h0;

    // ************************************************************
    // timing and frame counts
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int BIT_TIME_NS = 320;
    localparam int BIT_CYCLES_DEF = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int DATA_BITS = 8;
    localparam int LIN_BRK_BITS = 13;
    localparam int STD_BRK_BITS = 10;
    localparam int DET_SHORT_BITS = 10;
    localparam int DET_LONG_BITS = 11;
    localparam int IDLE_BITS = 10;
    // stop length in half bits
    localparam logic [4:0] STOP_H_1 = 5'h02;
    localparam logic [4:0] STOP_H_05 = 5'h01;
    localparam logic [4:0] STOP_H_2 = 5'h04;
    localparam logic [4:0] STOP_H_15 = 5'h03;
    localparam logic [15:0] LC_MAX = 16'hffff;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        T_IDLE = 3'b000,
        T_START = 3'b001,
        T_DATA = 3'b010,
        T_STOP = 3'b011,
        T_BRK = 3'b100
    } ufl_tx_st_t;

    typedef enum logic [1:0] {
        R_IDLE = 2'b00,
        R_DATA = 2'b01,
        R_STOP = 2'b10
    } ufl_rx_st_t;

    typedef struct packed {
        logic [16:0] rsv_hi;
        logic lin_mode_on;
        logic [1:0] stop_len;
        logic sync_clock_pin_on;
        logic sync_clock_idle_level;
        logic sync_clock_capture_phase;
        logic final_bit_pulse_on;
        logic rsv7;
        logic break_detect_irq_on;
        logic break_detect_length;
        logic rsv4;
        logic [3:0] node_addr;
    } ufl_cr2_t;

    typedef struct packed {
        logic tx;
        logic ck;
        logic ck_oe;
    } ufl_pins_t;
endpackage : ufl_pkg
`default_nettype wire

//--- verification/ufl_node.sv
// remote serial node that drives the block's receive line
`default_nettype none
module ufl_node (
    input wire logic link_clk, // bit-rate clock of the remote node
    output logic line          // serial line toward the block
);
    timeunit 1ns;
    timeprecision 1ps;

    // the line has a pull-up, so a silent node leaves it high
    initial begin
        line = 1'b1;
    end

    // one frame: start bit, eight data bits lsb first, one stop bit
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge link_clk);
            line <= f[i];
        end
        @(posedge link_clk);
    endtask : send_byte

    // a low run of whole bit times, as a break would make it
    task automatic hold_low(input int nb);
        @(posedge link_clk);
        line <= 1'b0;
        repeat (nb) @(posedge link_clk);
        line <= 1'b1;
    endtask : hold_low
endmodule : ufl_node
`default_nettype wire

//--- verification/ufl_core_tb_top.sv
// self-checking bench of the frame, clock and lin block
`default_nettype none
module ufl_core_tb_top
    import ufl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 8; // clocks per bit, 320 ns
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic link_clk = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, irq, rx_pin, tx_pin, rerr;
    logic sync_clock_pin, sync_clock_pin_oe;
    int num_errors = 0;
    int num_checks = 0;
    // frame rows: control word beside the clock pulses it should give
    logic [31:0] fr_cr2 [5] = '{32'h0000_0000, 32'h0000_1b00,
        32'h0000_2c00, 32'h0000_3b00, 32'h0000_0e00};
    int fr_pulses [5] = '{0, 8, 7, 8, 7};
    int stop_halves [4] = '{2, 1, 4, 3};
    // break rows: control word, low run in bits, flag expected
    logic [31:0] bd_cr2 [5] = '{32'h0000_4040, 32'h0000_4040,
        32'h0000_4060, 32'h0000_4060, 32'h0000_4020};
    int bd_bits [5] = '{9, 10, 10, 11, 12};
    logic bd_flag [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

    // clocks: the link clock is offset 7 ns so its edges never line up with ours
    always #20 clock = ~clock;
    always begin
        #7;
        forever #160 link_clk = ~link_clk;
    end

    ufl_core #(.BIT_CYCLES(BC)) i_dut (.clock(clock), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .sync_clock_pin(sync_clock_pin),
        .sync_clock_pin_oe(sync_clock_pin_oe));
    ufl_node i_node (.link_clk(link_clk), .line(rx_pin));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time,
                what, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen high, and
    // only the watchdog ends a wait that never gets its answer
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(n), 32'h2, "bus wait states");
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        xfer(1'b0, a, ZERO_WORD);
    endtask : rd

    task automatic wait_low();
        int k;
        k = 0;
        while (tx_pin !== 1'b0 && k < 50) begin
            @(negedge clock);
            k++;
        end
    endtask : wait_low

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // watchdog, far beyond the few thousand cycles the run needs
    initial begin
        #1_000_000;
        num_errors++;
        stop_test();
    end

    // main sequence
    initial begin : main
        int n, pulses, base, h;
        logic [31:0] cr;
        logic pol, prev;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        chk(32'(sync_clock_pin_oe), 32'h0, "pin enable");
        rd(OFS_CR2);
        chk(rdat, CR2_RST, "reset value");
        wr(OFS_CR2, 32'hffff_ffff);
        rd(OFS_CR2);
        chk(rdat, CR2_WMASK, "writable bits");
        rd(12'h020);
        chk(32'(rerr), 32'h1, "unmapped error");
        for (int i = 0; i < 5; i++) begin
            cr = fr_cr2[i];
            pol = cr[10];
            wr(OFS_CR2, cr);
            wr(OFS_STS, 32'h0000_0007);
            wr(OFS_MSK, 32'h0000_0002);
            @(negedge clock);
            chk(32'(sync_clock_pin_oe), 32'(cr[11]), "enable");
            chk(32'(sync_clock_pin), 32'(pol), "idle level");
            wr(OFS_DATA, ZERO_WORD);
            wait_low();
            n = 0;
            pulses = 0;
            prev = sync_clock_pin;
            while (irq !== 1'b1 && n < 400) begin
                @(negedge clock);
                n++;
                if (sync_clock_pin !== prev && prev === pol) pulses++;
                prev = sync_clock_pin;
                if (n == 4) chk(32'(sync_clock_pin), 32'(pol), "start");
                if (n == 10) chk(32'(sync_clock_pin),
                    32'(pol ^ (cr[11] & cr[9])), "first half");
            end
            if (i == 0) base = n;
            h = stop_halves[cr[13:12]];
            chk(32'(n), 32'(base + (h - 2) * BC / 2), "length");
            chk(32'(pulses), 32'(fr_pulses[i]), "pulses");
            chk(32'(sync_clock_pin), 32'(pol), "idle after");
        end
        // break send with lin on, request held until its stop bit ends
        wr(OFS_CR2, 32'h0000_4000);
        wr(OFS_CTRL, 32'h0000_0001);
        wait_low();
        n = 0;
        while (tx_pin === 1'b0 && n < 300) begin
            @(negedge clock);
            n++;
        end
        chk(32'(n), 32'(LIN_BRK_BITS * BC), "break length");
        rd(OFS_CTRL);
        chk(32'(rdat[CTL_SBK]), 32'h1, "request in stop");
        repeat (2 * BC) @(posedge clock);
        rd(OFS_CTRL);
        chk(32'(rdat[CTL_SBK]), 32'h0, "request cleared");
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CR2, bd_cr2[i]);
            wr(OFS_STS, 32'h0000_0007);
            i_node.hold_low(bd_bits[i]);
            repeat (5 * BC) @(posedge clock);
            rd(OFS_STS);
            chk(32'(rdat[ST_BRK]), 32'(bd_flag[i]), "flag");
            chk(32'(irq), 32'(bd_flag[i] & bd_cr2[i][6]), "irq");
            wr(OFS_STS, 32'h0000_0001);
            repeat (2) @(posedge clock);
            chk(32'(irq), 32'h0, "irq cleared");
        end
        // address wake, then idle line wake
        wr(OFS_CR2, 32'h0000_0005);
        wr(OFS_MSK, 32'h0000_0004);
        wr(OFS_STS, 32'h0000_0007);
        wr(OFS_CTRL, 32'h0000_0006);
        i_node.send_byte(8'h83);
        repeat (BC) @(posedge clock);
        rd(OFS_CTRL);
        chk(32'(rdat[CTL_MUTE]), 32'h1, "other address");
        i_node.send_byte(8'h85);
        repeat (BC) @(posedge clock);
        rd(OFS_CTRL);
        chk(32'(rdat[CTL_MUTE]), 32'h0, "own address");
        chk(32'(irq), 32'h1, "wake irq");
        wr(OFS_STS, 32'h0000_0007);
        wr(OFS_CTRL, 32'h0000_0002);
        rd(OFS_CTRL);
        chk(32'(rdat[CTL_MUTE]), 32'h1, "muted");
        repeat (12 * BC) @(posedge clock);
        rd(OFS_CTRL);
        chk(32'(rdat[CTL_MUTE]), 32'h0, "idle wake");
        stop_test();
    end
endmodule : ufl_core_tb_top
`default_nettype wire
